/* bbe_defs.svh */
// constants of the beam blanking evaluator
// assumes a 15-beam curtain sampled once per scan strobe
`ifndef BBE_DEFS_SVH
`define BBE_DEFS_SVH
`define BBE_NBEAM 15
`define BBE_MAX_AREAS 4'h3
`define BBE_MIN_GAP 4'h3
`define BBE_MIN_OBJ 4'h2
`define BBE_TOL_FINE_MAX 4'h8
`define BBE_TOL_COARSE_MAX 4'h4
`define BBE_TOL_RST 4'h0
`define BBE_RUN_INIT 4'hf
`endif

/* bbe_pkg.sv */
// types of the beam blanking evaluator
// assumes bbe_defs.svh supplies the constants
package bbe_pkg;
   typedef enum logic [1:0] {
      BBE_MODE_FLOAT = 2'b01,
      BBE_MODE_REDRES = 2'b10
   } bbe_mode_t;

   typedef struct packed {
      bbe_mode_t mode;
      logic [1:0] obj_cnt;
      logic [3:0] min_sz;
      logic [3:0] max_sz;
      logic coarse;
      logic part_mute;
      logic full_mute;
   } bbe_cfg_t;

   typedef struct packed {
      logic [3:0] runs;
      logic [3:0] max_run;
      logic [3:0] min_run;
      logic [3:0] min_gap;
      logic at_end;
   } bbe_scan_t;
endpackage : bbe_pkg

/* bbe_evaluator.sv */
// beam blanking evaluator: floating blanking and reduced resolution
// assumes beam pins and scan strobe are asynchronous; config is on ref_clk
`include "bbe_defs.svh"
module bbe_evaluator (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // receiver optics
   input wire logic [`BBE_NBEAM-1:0] beam_blocked_pin,
   input wire logic scan_strobe_pin,
   // configuration
   input wire bbe_pkg::bbe_cfg_t cfg,
   input wire logic teach_valid,
   input wire logic [3:0] teach_tol,
   input wire logic iolink_wr_valid,
   input wire logic [3:0] iolink_tol,
   // results
   output logic [1:0] safety_switch_output,
   output logic err_flag,
   output logic pen_flag,
   output logic scan_done,
   output logic tol_reject,
   output logic [3:0] tol_value
);
   // ************************************************************
   // scan analysis
   // ************************************************************
   function automatic bbe_pkg::bbe_scan_t bbe_scan(input logic [`BBE_NBEAM-1:0] v);
      bbe_pkg::bbe_scan_t s;
      logic [3:0] run;
      logic [3:0] gap;
      s.runs = 4'h0;
      s.max_run = 4'h0;
      s.min_run = `BBE_RUN_INIT;
      s.min_gap = `BBE_RUN_INIT;
      run = 4'h0;
      gap = 4'h0;
      for (int i = 0; i < `BBE_NBEAM; i++) begin
         if (v[i]) begin
            if (run == 4'h0 && s.runs != 4'h0 && gap < s.min_gap) begin
               s.min_gap = gap;
            end
            if (run == 4'h0) begin
               s.runs = s.runs + 4'h1;
            end
            run = run + 4'h1;
            gap = 4'h0;
            if (run > s.max_run) begin
               s.max_run = run;
            end
         end else begin
            if (run != 4'h0 && run < s.min_run) begin
               s.min_run = run;
            end
            run = 4'h0;
            gap = gap + 4'h1;
         end
      end
      if (run != 4'h0 && run < s.min_run) begin
         s.min_run = run;
      end
      s.at_end = v[0] | v[`BBE_NBEAM-1];
      return s;
   endfunction : bbe_scan

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [`BBE_NBEAM-1:0] beam_s1_q;
   logic [`BBE_NBEAM-1:0] beam_s2_q;
   logic strobe_s1_q;
   logic strobe_s2_q;
   logic strobe_s3_q;
   logic scan_evt;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         beam_s1_q <= '0;
         beam_s2_q <= '0;
         strobe_s1_q <= 1'b0;
         strobe_s2_q <= 1'b0;
         strobe_s3_q <= 1'b0;
      end else begin
         beam_s1_q <= beam_blocked_pin;
         beam_s2_q <= beam_s1_q;
         strobe_s1_q <= scan_strobe_pin;
         strobe_s2_q <= strobe_s1_q;
         strobe_s3_q <= strobe_s2_q;
      end
   end

   assign scan_evt = strobe_s2_q & ~strobe_s3_q;

   // ************************************************************
   // tolerance setting
   // ************************************************************
   logic [3:0] tol_q;
   logic tol_rej_q;
   logic tol_wr;
   logic [3:0] tol_new;
   logic [3:0] tol_lim;

   assign tol_lim = cfg.coarse ? `BBE_TOL_COARSE_MAX : `BBE_TOL_FINE_MAX;
   assign tol_wr = teach_valid | iolink_wr_valid;
   assign tol_new = teach_valid ? teach_tol : iolink_tol;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tol_q <= `BBE_TOL_RST;
         tol_rej_q <= 1'b0;
      end else begin
         tol_rej_q <= tol_wr & (tol_new > tol_lim);
         if (tol_wr && tol_new <= tol_lim) begin
            tol_q <= tol_new;
         end else if (tol_q > tol_lim) begin
            tol_q <= tol_lim;
         end
      end
   end

   // ************************************************************
   // evaluation
   // ************************************************************
   bbe_pkg::bbe_scan_t sc;
   logic is_float;
   logic is_red;
   logic cfg_bad;
   logic float_err;
   logic res_err;
   logic res_pen;

   assign sc = bbe_scan(beam_s2_q);
   assign is_float = (cfg.mode == bbe_pkg::BBE_MODE_FLOAT);
   assign is_red = (cfg.mode == bbe_pkg::BBE_MODE_REDRES);

   always_comb begin
      cfg_bad = !(is_float || is_red);
      if (is_red && (cfg.part_mute || cfg.full_mute)) begin
         cfg_bad = 1'b1;
      end
      if (is_float && (cfg.obj_cnt == 2'h0 || {2'h0, cfg.obj_cnt} > `BBE_MAX_AREAS
            || cfg.min_sz < `BBE_MIN_OBJ || cfg.max_sz < cfg.min_sz)) begin
         cfg_bad = 1'b1;
      end
   end

   always_comb begin
      float_err = 1'b0;
      if (sc.runs != {2'h0, cfg.obj_cnt}) begin
         float_err = 1'b1;
      end
      if (sc.min_run < cfg.min_sz) begin
         float_err = 1'b1;
      end
      if (sc.at_end) begin
         float_err = 1'b1;
      end
      if (sc.min_gap < `BBE_MIN_GAP) begin
         float_err = 1'b1;
      end
   end

   always_comb begin
      res_err = cfg_bad | (is_float & float_err);
      res_pen = 1'b0;
      if (!res_err && is_float && sc.max_run > cfg.max_sz) begin
         res_pen = 1'b1;
      end
      if (!res_err && is_red && sc.max_run > tol_q) begin
         res_pen = 1'b1;
      end
   end

   // ************************************************************
   // result registers
   // ************************************************************
   logic [1:0] ssw_q;
   logic err_q;
   logic pen_q;
   logic done_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ssw_q <= 2'h0;
         err_q <= 1'b0;
         pen_q <= 1'b0;
      end else if (scan_evt) begin
         ssw_q <= {2{~(res_err | res_pen)}};
         err_q <= res_err;
         pen_q <= res_pen;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         done_q <= 1'b0;
      end else begin
         done_q <= scan_evt;
      end
   end

   assign safety_switch_output = ssw_q;
   assign err_flag = err_q;
   assign pen_flag = pen_q;
   assign scan_done = done_q;
   assign tol_reject = tol_rej_q;
   assign tol_value = tol_q;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   property p_count_match;
      scan_evt && is_float && sc.runs != {2'h0, cfg.obj_cnt} |=> err_q && ssw_q == 2'h0;
   endproperty
   a_count_match: assert property (p_count_match)
      else $error("object count mismatch did not give error");

   property p_vanish;
      scan_evt && is_float && sc.runs == 4'h0 |=> err_q && !pen_q;
   endproperty
   a_vanish: assert property (p_vanish)
      else $error("vanished object did not give error");

   property p_sync_beam;
      scan_evt && is_float && (beam_s2_q[0] || beam_s2_q[`BBE_NBEAM-1]) |=> err_q;
   endproperty
   a_sync_beam: assert property (p_sync_beam)
      else $error("object on sync beam not an error");

   property p_too_long;
      scan_evt && !res_err && is_float && sc.max_run > cfg.max_sz |=> pen_q && !err_q;
   endproperty
   a_too_long: assert property (p_too_long)
      else $error("oversize object not a penetration");

   property p_close;
      scan_evt && is_float && sc.min_gap < `BBE_MIN_GAP |=> err_q && !pen_q;
   endproperty
   a_close: assert property (p_close)
      else $error("close objects not an error");

   property p_one_cause;
      !(err_q && pen_q) && (ssw_q == 2'h3 || ssw_q == 2'h0);
   endproperty
   a_one_cause: assert property (p_one_cause)
      else $error("both causes set or output pair split");

   property p_red_ok;
      scan_evt && is_red && !cfg_bad && sc.max_run <= tol_q |=> ssw_q == 2'h3;
   endproperty
   a_red_ok: assert property (p_red_ok)
      else $error("reduced resolution switched off on small runs");

   property p_mute_refuse;
      scan_evt && is_red && (cfg.part_mute || cfg.full_mute) |=> err_q && ssw_q == 2'h0;
   endproperty
   a_mute_refuse: assert property (p_mute_refuse)
      else $error("muting with reduced resolution accepted");

   property p_tol_limit;
      tol_wr && tol_new > tol_lim |=> tol_reject && $stable(tol_q);
   endproperty
   a_tol_limit: assert property (p_tol_limit)
      else $error("out of range tolerance accepted");

   property p_red_pen;
      scan_evt && is_red && !cfg_bad && sc.max_run > tol_q |=> pen_q ##1 pen_q || scan_evt;
   endproperty
   a_red_pen: assert property (p_red_pen)
      else $error("long run not a penetration");

   property p_teach;
      teach_valid && teach_tol <= tol_lim |=> tol_q == $past(teach_tol);
   endproperty
   a_teach: assert property (p_teach)
      else $error("taught tolerance not loaded");

   property p_hold;
      !scan_evt |=> $stable(ssw_q) && $stable(err_q) && $stable(pen_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("outputs changed outside scan end");

   property p_shrink;
      scan_evt && is_float && sc.min_run < cfg.min_sz |=> err_q && ssw_q == 2'h0;
   endproperty
   a_shrink: assert property (p_shrink)
      else $error("undersize or freed hidden area not an error");

   property p_bad_float_cfg;
      scan_evt && is_float && cfg_bad |=> err_q && !pen_q && ssw_q == 2'h0;
   endproperty
   a_bad_float_cfg: assert property (p_bad_float_cfg)
      else $error("invalid floating configuration accepted");

   property p_done;
      scan_evt |=> scan_done;
   endproperty
   a_done: assert property (p_done)
      else $error("scan end not flagged");

   property p_tol_clamp;
      !tol_wr && tol_q > tol_lim |=> tol_q == $past(tol_lim);
   endproperty
   a_tol_clamp: assert property (p_tol_clamp)
      else $error("tolerance above variant limit kept");

   c_float_on: cover property (scan_evt && is_float && !res_err && !res_pen);
   c_float_pen: cover property (scan_evt && is_float && res_pen);
   c_red_many: cover property (scan_evt && is_red && sc.runs > 4'h2 && !res_pen);
   c_iolink: cover property (iolink_wr_valid && !teach_valid && iolink_tol <= tol_lim);
endmodule : bbe_evaluator

/* bbe_beam_array.sv */
// partner model: emitter beam array and receiver scan strobe
// assumes the bench calls present, waits for the result, then finish_scan
module bbe_beam_array (
   // clock
   input wire logic ref_clk,
   // receiver optics
   output logic [14:0] beam_blocked_pin,
   output logic scan_strobe_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // ******************************
   // beam vector and scan strobe
   // ******************************
   initial begin
      beam_blocked_pin = 15'h0000;
      scan_strobe_pin = 1'b0;
   end
   // bit 0 is beam 1, bit 14 is beam 15; beams settle 3 cycles before strobe
   task automatic present(input logic [14:0] pat);
      @(posedge ref_clk);
      beam_blocked_pin <= pat;
      repeat (3) @(posedge ref_clk);
      scan_strobe_pin <= 1'b1;
   endtask : present
   // strobe low for at least 2 cycles before the next scan
   task automatic finish_scan();
      @(posedge ref_clk);
      scan_strobe_pin <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : finish_scan
endmodule : bbe_beam_array

/* beam_blanking_evaluator_test.sv */
// testbench of the beam blanking evaluator
// assumes bbe_pkg, bbe_evaluator and bbe_beam_array are compiled first
module beam_blanking_evaluator_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ******************************
   // signals and instances
   // ******************************
   logic ref_clk;
   logic rst_n;
   logic [14:0] beam;
   logic strobe;
   bbe_pkg::bbe_cfg_t cfg;
   logic teach_valid;
   logic iolink_wr_valid;
   logic [3:0] teach_tol;
   logic [3:0] iolink_tol;
   logic [3:0] tol_value;
   logic [1:0] ssw;
   logic err_flag;
   logic pen_flag;
   logic scan_done;
   logic tol_reject;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   localparam logic [4:0] exp_on = 5'h1c;
   localparam logic [4:0] exp_err = 5'h12;
   localparam logic [4:0] exp_pen = 5'h11;
   bbe_beam_array u_bbe_beam_array (.ref_clk(ref_clk), .beam_blocked_pin(beam),
      .scan_strobe_pin(strobe));
   bbe_evaluator u_bbe_evaluator (.ref_clk(ref_clk), .rst_n(rst_n), .beam_blocked_pin(beam),
      .scan_strobe_pin(strobe), .cfg(cfg), .teach_valid(teach_valid), .teach_tol(teach_tol),
      .iolink_wr_valid(iolink_wr_valid), .iolink_tol(iolink_tol), .safety_switch_output(ssw),
      .err_flag(err_flag), .pen_flag(pen_flag), .scan_done(scan_done),
      .tol_reject(tol_reject), .tol_value(tol_value));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors = num_errors + 1;
         give_verdict();
      end
   end
   // ******************************
   // shared tasks
   // ******************************
   task automatic give_verdict();
      if (num_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic check_val(input logic [4:0] got, input logic [4:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val
   task automatic set_cfg(input bbe_pkg::bbe_mode_t m, input logic [1:0] n, input logic c,
      input logic pm, input logic fm);
      @(posedge ref_clk);
      cfg <= '{mode: m, obj_cnt: n, min_sz: 4'h2, max_sz: 4'h4, coarse: c, part_mute: pm,
         full_mute: fm};
   endtask : set_cfg
   // one scan; result judged in the cycle scan_done is high
   task automatic scan(input logic [14:0] pat, input logic [4:0] exp);
      int i;
      u_bbe_beam_array.present(pat);
      for (i = 0; i < 10 && scan_done !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      check_val({scan_done, ssw, err_flag, pen_flag}, exp);
      u_bbe_beam_array.finish_scan();
   endtask : scan
   task automatic write_tol(input logic tch, input logic iol, input logic [3:0] tv,
      input logic [3:0] iv, input logic [4:0] exp);
      @(posedge ref_clk);
      teach_valid <= tch;
      teach_tol <= tv;
      iolink_wr_valid <= iol;
      iolink_tol <= iv;
      @(posedge ref_clk);
      teach_valid <= 1'b0;
      iolink_wr_valid <= 1'b0;
      // reject pulse stands only in the cycle after the write edge
      #1;
      check_val({tol_reject, tol_value}, exp);
   endtask : write_tol
   // ******************************
   // scenarios
   // ******************************
   task automatic t_float_two();
      set_cfg(bbe_pkg::BBE_MODE_FLOAT, 2'h2, 1'b0, 1'b0, 1'b0);
      scan(15'h0e38, exp_on);
      scan(15'h0e0e, exp_on);
      scan(15'h0e07, exp_err); // first end beam
      scan(15'h0ee0, exp_err); // too close
      scan(15'h3838, exp_on);
      scan(15'h07e0, exp_err); // merged
      scan(15'h0e0c, exp_on);
      scan(15'h0e3c, exp_on);
      scan(15'h0e3e, exp_pen); // oversize
      scan(15'h0e08, exp_err); // hidden beam freed
      scan(15'h0038, exp_err); // object gone
      scan(15'h7038, exp_err); // last end beam
   endtask : t_float_two
   task automatic t_three_areas();
      set_cfg(bbe_pkg::BBE_MODE_FLOAT, 2'h3, 1'b0, 1'b0, 1'b0);
      scan(15'h18c6, exp_on); // gaps of 3
      scan(15'h0c66, exp_err); // gap of 2
   endtask : t_three_areas
   task automatic t_reduced();
      set_cfg(bbe_pkg::BBE_MODE_REDRES, 2'h0, 1'b0, 1'b0, 1'b0);
      write_tol(1'b0, 1'b1, 4'h0, 4'h2, 5'h02);
      scan(15'h0000, exp_on);
      scan(15'h0620, exp_on);
      scan(15'h6001, exp_on);
      scan(15'h0e20, exp_pen); // run of 3
      scan(15'h0020, exp_on);
      write_tol(1'b1, 1'b0, 4'h0, 4'h0, 5'h00);
      scan(15'h0020, exp_pen);
   endtask : t_reduced
   task automatic t_muting();
      set_cfg(bbe_pkg::BBE_MODE_REDRES, 2'h0, 1'b0, 1'b1, 1'b0);
      scan(15'h0000, exp_err);
      set_cfg(bbe_pkg::BBE_MODE_REDRES, 2'h0, 1'b0, 1'b0, 1'b1);
      scan(15'h0000, exp_err);
      set_cfg(bbe_pkg::bbe_mode_t'(2'h3), 2'h0, 1'b0, 1'b0, 1'b0);
      scan(15'h0000, exp_err); // bad mode
      set_cfg(bbe_pkg::BBE_MODE_FLOAT, 2'h0, 1'b0, 1'b0, 1'b0);
      scan(15'h0000, exp_err); // no area taught
   endtask : t_muting
   task automatic t_tol_limits();
      set_cfg(bbe_pkg::BBE_MODE_REDRES, 2'h0, 1'b0, 1'b0, 1'b0);
      write_tol(1'b1, 1'b0, 4'h8, 4'h0, 5'h08);
      write_tol(1'b1, 1'b0, 4'h9, 4'h0, 5'h18);
      set_cfg(bbe_pkg::BBE_MODE_REDRES, 2'h0, 1'b1, 1'b0, 1'b0);
      write_tol(1'b0, 1'b0, 4'h0, 4'h0, 5'h04); // clamp to coarse
      write_tol(1'b1, 1'b1, 4'h3, 4'h6, 5'h03); // teach wins
      set_cfg(bbe_pkg::BBE_MODE_REDRES, 2'h0, 1'b1, 1'b0, 1'b0);
      write_tol(1'b0, 1'b1, 4'h0, 4'h5, 5'h13);
      write_tol(1'b0, 1'b1, 4'h0, 4'h4, 5'h04);
   endtask : t_tol_limits
   initial begin
      rst_n = 1'b0;
      cfg = '0;
      teach_valid = 1'b0;
      teach_tol = 4'h0;
      iolink_wr_valid = 1'b0;
      iolink_tol = 4'h0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      check_val({scan_done, ssw, err_flag, pen_flag}, 5'h00);
      t_float_two();
      t_three_areas();
      t_reduced();
      t_muting();
      t_tol_limits();
      give_verdict();
   end
endmodule : beam_blanking_evaluator_test
